// ### test/tisl_host.sv
// Host model issuing reads on the status read port
`timescale 1ns/1ps

module tisl_host (
  // Clock and read port
  input wire logic        clk,
  output logic            rd_en,
  output logic [5:0]      rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic        rd_valid
);
  initial begin
    rd_en = 1'b0;
    rd_addr = 6'h00;
  end

  // One strobe per read; the answer is awaited a few cycles only
  task automatic read(input logic [5:0] a, output logic [15:0] d, output logic ok);
    int i;
    repeat (2) @(posedge clk);
    #1 rd_en = 1'b1;
    rd_addr = a;
    @(posedge clk);
    #1 rd_en = 1'b0;
    rd_addr = ~a; // Idle address flips so a stale one is never relied on
    for (i = 0; i < 4 && rd_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    ok = (rd_valid === 1'b1);
    d = rd_data;
  endtask
endmodule

// ### test/tisl_irq_status_chk.sv
// Assertion checker for the interrupt status logic
`timescale 1ns/1ps

module tisl_irq_status_chk #(
  parameter int TIMER_W      = tisl_pkg::TIMER_W,
  parameter int STREAM_CMP_W = tisl_pkg::STREAM_CMP_W
) (
  // Clock, reset and read port
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          reg_rd_en,
  input wire logic [tisl_pkg::ADDR_W-1:0]   reg_rd_addr,
  input wire logic [tisl_pkg::DATA_W-1:0]   reg_rd_data,
  input wire logic                          reg_rd_valid,
  // Configuration, events and request
  input wire logic                          stream_mode_sel,
  input wire logic [1:0]                    cca_type,
  input wire logic [tisl_pkg::LOW_BITS-1:0] irq_enable,
  input wire logic [TIMER_W-1:0]            event_timer,
  input wire logic [TIMER_W-1:0]            compare_two_value,
  input wire logic                          doze_active,
  input wire logic                          doze_wake,
  input wire logic                          pkt_rx_done,
  input wire logic                          irq_n
);
  // Previous compare-2 equality; starts high so no wake is owed right after reset
  logic eq2_reg;
  always_ff @(posedge clk) eq2_reg <= rst | (event_timer == compare_two_value);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ans; reg_rd_en |=> reg_rd_valid; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_no_ans; !reg_rd_en |=> !reg_rd_valid && reg_rd_data == 16'h0000; endproperty
  a_no_ans: assert property (p_no_ans) else $error("answer without read");
  property p_unmapped; reg_rd_en && reg_rd_addr != tisl_pkg::STATUS_OFFSET |=> reg_rd_data == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rx; pkt_rx_done && !stream_mode_sel && irq_enable[7] |=> !irq_n; endproperty
  a_rx: assert property (p_rx) else $error("packet received gave no request");
  property p_sticky; !irq_n && !reg_rd_en && $stable(irq_enable) |=> !irq_n; endproperty
  a_sticky: assert property (p_sticky) else $error("request dropped without read");
  property p_wake; doze_active && !eq2_reg && event_timer == compare_two_value |=> doze_wake; endproperty
  a_wake: assert property (p_wake) else $error("doze match gave no wake");
  property p_wake_cause; doze_wake |-> $past(doze_active); endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake outside doze");
  property p_energy; cca_type == 2'h2 && $past(cca_type) == 2'h2 && reg_rd_en |=> !reg_rd_data[1]; endproperty
  a_energy: assert property (p_energy) else $error("busy bit set in energy mode");
  property p_quiet; irq_enable[10:2] == 9'h000 |=> irq_n; endproperty
  a_quiet: assert property (p_quiet) else $error("request with no enable");

  // Main scenarios reached
  c_read: cover property (reg_rd_valid && reg_rd_data != 16'h0000);
  c_wake: cover property (doze_wake);
  c_irq: cover property ($fell(irq_n));
endmodule

bind tisl_irq_status tisl_irq_status_chk #(.TIMER_W(TIMER_W), .STREAM_CMP_W(STREAM_CMP_W)) u_tisl_irq_status_chk (
  .clk, .rst, .reg_rd_en, .reg_rd_addr, .reg_rd_data, .reg_rd_valid, .stream_mode_sel, .cca_type,
  .irq_enable, .event_timer, .compare_two_value, .doze_active, .doze_wake, .pkt_rx_done, .irq_n);

// ### test/tisl_irq_status_tb.sv
// Self-checking testbench for the interrupt status logic
`timescale 1ns/1ps

module tisl_irq_status_tb;
  logic clk = 1'b0, rst = 1'b1, rd_en, rd_valid, doze_wake, irq_n, wake_seen = 1'b0;
  logic mode = 1'b0, cmp_en = 1'b1, doze = 1'b0, attn_n = 1'b1, cca_busy = 1'b0, crc_ok = 1'b0;
  logic [5:0] rd_addr;
  logic [15:0] rd_data;
  logic [1:0] cca_type = 2'h0;
  logic [10:0] irq_en = 11'h7FC;
  logic [7:0] pulse = 8'h00;
  logic [23:0] timer = 24'h000123;
  logic [23:0] cmpv [5] = '{default: 24'hFFFFFF};
  int kind [13] = '{0, 7, 1, 2, 5, 9, 10, 8, 3, 4, 11, 1, 3};
  logic [15:0] expv [13] = '{16'h0400, 16'h0100, 16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0008,
                             16'h0004, 16'h0080, 16'h0040, 16'h0004, 16'h0000, 16'h0000};
  int n_errors = 0, cmp_count = 0, i;

  always #5 clk = ~clk;
  // Wake pulse lasts one cycle, so it is latched here
  always @(posedge clk) if (doze_wake === 1'b1) wake_seen <= 1'b1;

  tisl_irq_status u_tisl_irq_status (
    .clk(clk), .rst(rst), .reg_rd_en(rd_en), .reg_rd_addr(rd_addr), .reg_rd_data(rd_data),
    .reg_rd_valid(rd_valid), .stream_mode_sel(mode), .stream_compare_en(cmp_en), .cca_type(cca_type),
    .irq_enable(irq_en), .event_timer(timer), .compare_one_value(cmpv[0]), .compare_two_value(cmpv[1]),
    .compare_three_value(cmpv[2]), .compare_four_value(cmpv[3]), .stream_compare_value(cmpv[4][15:0]),
    .attn_n(attn_n), .power_up_done(pulse[0]), .doze_active(doze), .doze_wake(doze_wake),
    .pkt_rx_done(pulse[1]), .pkt_tx_done(pulse[2]), .strm_rx_ready(pulse[3]), .strm_tx_ready(pulse[4]),
    .cca_done(pulse[5]), .cca_busy(cca_busy), .crc_done(pulse[6]), .crc_ok(crc_ok), .irq_n(irq_n));

  tisl_host u_tisl_host (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));

  task automatic results();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    u_tisl_host.read(a, d, ok);
    if (ok !== 1'b1) begin
      check(16'h0001, 16'h0000);
      results();
    end else check(d, exp);
  endtask

  // Pulses 0..6 last one cycle; 7..11 make one compare equal for one cycle
  task automatic fire(input int k);
    @(posedge clk);
    #1 if (k < 7) pulse[k] = 1'b1;
    else cmpv[k-7] = timer;
    @(posedge clk);
    #1 pulse = 8'h00;
    foreach (cmpv[j]) cmpv[j] = 24'hFFFFFF;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    rd(6'h24, 16'h0000);
    for (i = 0; i < 13; i++) begin
      mode = (i >= 8 && i <= 11);
      fire(kind[i]);
      check({15'h0000, irq_n}, {15'h0000, expv[i] == 16'h0000});
      rd(6'h24, expv[i]);
      rd(6'h24, 16'h0000);
    end
    mode = 1'b1;
    fire(8);
    rd(6'h24, 16'h0000);
    cmp_en = 1'b0;
    fire(8);
    rd(6'h24, 16'h0004);
    mode = 1'b0;
    check({15'h0000, wake_seen}, 16'h0000);
    doze = 1'b1;
    fire(8);
    doze = 1'b0;
    rd(6'h24, 16'h0204);
    check({15'h0000, wake_seen}, 16'h0001);
    attn_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 attn_n = 1'b1;
    rd(6'h24, 16'h0400);
    fire(7);
    repeat (20) @(posedge clk);
    check({15'h0000, irq_n}, 16'h0000);
    rd(6'h24, 16'h0100);
    check({15'h0000, irq_n}, 16'h0001);
    irq_en = 11'h003; // Result bits only: they must never raise a request
    crc_ok = 1'b1;
    fire(6);
    check({15'h0000, irq_n}, 16'h0001);
    rd(6'h24, 16'h0001);
    rd(6'h24, 16'h0001);
    crc_ok = 1'b0;
    fire(6);
    rd(6'h24, 16'h0000);
    cca_busy = 1'b1;
    fire(5);
    check({15'h0000, irq_n}, 16'h0001);
    rd(6'h24, 16'h0022);
    rd(6'h24, 16'h0002);
    cca_type = 2'h2;
    rd(6'h24, 16'h0000);
    rd(6'h25, 16'h0000);
    results();
  end
endmodule

// ### verilog/tisl_irq_status.sv
// Interrupt event status register, low eleven bits, of the transceiver
// Contract
// - Attention bit on pin low or power-up
// - Doze compare-2 match sets doze bit, exits doze
// - Compare 1, 3, 4 matches set their bits
// - Compare-2 bit, or stream 16-bit compare match
// - Packet mode: bit 7 is packet received
// - Stream mode: bit 7 is length/word ready
// - Packet mode: bit 6 is packet sent
// - Stream mode: bit 6 is transmit word needed
// - Stream select bit chooses bit 7/6 meaning
// - Assessment completion sets assessment-done bit
// - Bit 1 shows channel busy or idle
// - Energy-detect type holds busy bit at zero
// - Bit 0 shows checksum correct, default zero
// - Enabled event bits raise request; read clears bits 10 to 2
`timescale 1ns/1ps

module tisl_irq_status #(
  parameter int TIMER_W      = tisl_pkg::TIMER_W,
  parameter int STREAM_CMP_W = tisl_pkg::STREAM_CMP_W
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Register read port from the serial interface
  input  wire logic                        reg_rd_en,
  input  wire logic [tisl_pkg::ADDR_W-1:0] reg_rd_addr,
  output logic      [tisl_pkg::DATA_W-1:0] reg_rd_data,
  output logic                             reg_rd_valid,
  // Configuration from other registers
  input  wire logic                        stream_mode_sel,
  input  wire logic                        stream_compare_en,
  input  wire logic [1:0]                  cca_type,
  input  wire logic [tisl_pkg::LOW_BITS-1:0] irq_enable,
  // Event timer and compare values
  input  wire logic [TIMER_W-1:0]          event_timer,
  input  wire logic [TIMER_W-1:0]          compare_one_value,
  input  wire logic [TIMER_W-1:0]          compare_two_value,
  input  wire logic [TIMER_W-1:0]          compare_three_value,
  input  wire logic [TIMER_W-1:0]          compare_four_value,
  input  wire logic [STREAM_CMP_W-1:0]     stream_compare_value,
  // Power and doze state
  input  wire logic                        attn_n,
  input  wire logic                        power_up_done,
  input  wire logic                        doze_active,
  output logic                             doze_wake,
  // Datapath events, one-cycle pulses, with the busy and checksum result levels
  input  wire logic                        pkt_rx_done,
  input  wire logic                        pkt_tx_done,
  input  wire logic                        strm_rx_ready,
  input  wire logic                        strm_tx_ready,
  input  wire logic                        cca_done,
  input  wire logic                        cca_busy,
  input  wire logic                        crc_done,
  input  wire logic                        crc_ok,
  // Interrupt request pin
  output logic                             irq_n
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Equality test shared by the four 24-bit timer comparators
  function automatic logic timer_hit(input logic [TIMER_W-1:0] a, input logic [TIMER_W-1:0] b);
    timer_hit = (a == b);
  endfunction

  // Register address decode, used for read clear and read data
  function automatic logic is_status(input logic [tisl_pkg::ADDR_W-1:0] addr);
    is_status = (addr == tisl_pkg::STATUS_OFFSET);
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [tisl_pkg::LOW_BITS-1:0] status_reg;
  logic [tisl_pkg::LOW_BITS-1:0] status_next;
  logic [tisl_pkg::LOW_BITS-1:0] status_set;
  logic [tisl_pkg::LOW_BITS-1:0] status_clr;
  logic [tisl_pkg::DATA_W-1:0]   rd_data_reg;
  logic [tisl_pkg::DATA_W-1:0]   rd_data_next;
  logic                          rd_valid_reg;
  logic                          irq_n_reg;
  logic                          irq_n_next;
  logic                          doze_wake_reg;
  logic                          attn_sync1_reg;
  logic                          attn_sync2_reg;
  logic                          attn_prev_reg;
  logic                          cca_busy_reg;
  logic                          cca_busy_next;
  logic                          crc_ok_reg;
  logic                          crc_ok_next;
  logic [tisl_pkg::NUM_CMP-1:0]  cmp_match;
  logic [tisl_pkg::NUM_CMP-1:0]  cmp_prev_reg;
  logic [tisl_pkg::NUM_CMP-1:0]  cmp_rise;
  logic [TIMER_W-1:0]            cmp_value [tisl_pkg::NUM_CMP];
  logic                          stream_hit;
  logic                          stream_prev_reg;
  logic                          stream_rise;
  logic                          stream_cmp_mode;
  logic                          cmp_two_event;
  logic                          doze_event;
  logic                          attn_fall;
  logic                          attn_event;
  logic                          rx_event;
  logic                          tx_event;
  logic                          status_read;
  logic                          energy_detect;

  // ****************************************************************
  // Attention pin synchroniser
  // ****************************************************************

  // Two stages before use; the pin is asynchronous to clk
  // Reset to the idle level, so leaving reset makes no false edge
  always_ff @(posedge clk) begin
    if (rst) begin
      attn_sync1_reg <= 1'b1;
      attn_sync2_reg <= 1'b1;
      attn_prev_reg  <= 1'b1;
    end else begin
      attn_sync1_reg <= attn_n;
      attn_sync2_reg <= attn_sync1_reg;
      attn_prev_reg  <= attn_sync2_reg;
    end
  end

  // Falling edge only, so a pin held low sets the bit once per assertion
  assign attn_fall  = attn_prev_reg & ~attn_sync2_reg;
  assign attn_event = attn_fall | power_up_done;

  // ****************************************************************
  // Timer comparators
  // ****************************************************************

  // Comparator table, index 0 to 3 for compare one to four
  assign cmp_value[0] = compare_one_value;
  assign cmp_value[1] = compare_two_value;
  assign cmp_value[2] = compare_three_value;
  assign cmp_value[3] = compare_four_value;

  // Rising edge of each match; a stalled timer sets the bit only once
  // Limitation: a timer that skips over a compare value misses it
  genvar gi;
  generate
    for (gi = 0; gi < tisl_pkg::NUM_CMP; gi++) begin : g_cmp
      assign cmp_match[gi] = timer_hit(event_timer, cmp_value[gi]);
      assign cmp_rise[gi]  = cmp_match[gi] & ~cmp_prev_reg[gi];
    end
  endgenerate

  // Stream compare against the timer's low 16 bits
  assign stream_hit      = (event_timer[STREAM_CMP_W-1:0] == stream_compare_value);
  assign stream_rise     = stream_hit & ~stream_prev_reg;
  assign stream_cmp_mode = stream_mode_sel & stream_compare_en;

  // Compare two takes the 16-bit source when stream mode and the stream compare are both on
  // The 24-bit match then drives only the doze wake
  assign cmp_two_event = stream_cmp_mode ? stream_rise : cmp_rise[1];

  // Doze wake always uses the full 24-bit compare two value
  assign doze_event = doze_active & cmp_rise[1];

  // Edge history for the comparators
  // Reset low, so a match present at reset exit counts as an event
  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_prev_reg    <= '0;
      stream_prev_reg <= 1'b0;
    end else begin
      cmp_prev_reg    <= cmp_match;
      stream_prev_reg <= stream_hit;
    end
  end

  // ****************************************************************
  // Multiplexed receive and transmit events
  // ****************************************************************

  // Source of bits 7 and 6 follows the stream select bit
  assign rx_event = stream_mode_sel ? strm_rx_ready : pkt_rx_done;
  assign tx_event = stream_mode_sel ? strm_tx_ready : pkt_tx_done;

  // ****************************************************************
  // Assessment and checksum results
  // ****************************************************************

  // Energy detect skips the busy calculation
  // Forced in the next state, so a stale busy result shows only to a read in the cycle the type changes
  assign energy_detect = (cca_type == tisl_pkg::CCA_TYPE_ENERGY);

  // Busy result updates when an assessment finishes, and clears under energy detect
  assign cca_busy_next = energy_detect ? 1'b0 :
                         (cca_done ? cca_busy : cca_busy_reg);

  // Checksum outcome of the last received frame
  // Zero until the first frame, which reads as incorrect
  assign crc_ok_next = crc_done ? crc_ok : crc_ok_reg;

  // Result bits held until the next outcome
  always_ff @(posedge clk) begin
    if (rst) begin
      cca_busy_reg <= 1'b0;
      crc_ok_reg   <= 1'b0;
    end else begin
      cca_busy_reg <= cca_busy_next;
      crc_ok_reg   <= crc_ok_next;
    end
  end

  // ****************************************************************
  // Sticky event bits
  // ****************************************************************

  // Event set vector in register bit order
  always_comb begin
    status_set                          = '0;
    status_set[tisl_pkg::BIT_ATTN]      = attn_event;
    status_set[tisl_pkg::BIT_DOZE]      = doze_event;
    status_set[tisl_pkg::BIT_CMP_ONE]   = cmp_rise[0];
    status_set[tisl_pkg::BIT_RX_EVENT]  = rx_event;
    status_set[tisl_pkg::BIT_TX_EVENT]  = tx_event;
    status_set[tisl_pkg::BIT_CCA_DONE]  = cca_done;
    status_set[tisl_pkg::BIT_CMP_THREE] = cmp_rise[2];
    status_set[tisl_pkg::BIT_CMP_FOUR]  = cmp_rise[3];
    status_set[tisl_pkg::BIT_CMP_TWO]   = cmp_two_event;
  end

  // A read of the status register clears the event bits
  assign status_read = reg_rd_en & is_status(reg_rd_addr);
  assign status_clr  = status_read ? tisl_pkg::EVENT_MASK : '0;

  // Set wins over the read clear, so an event in the read cycle survives
  assign status_next[tisl_pkg::LOW_BITS-1:2] =
           (status_reg[tisl_pkg::LOW_BITS-1:2] & ~status_clr[tisl_pkg::LOW_BITS-1:2]) |
           status_set[tisl_pkg::LOW_BITS-1:2];

  // Low two bits mirror the held results, not sticky events
  // A read leaves them alone; they never raise a request
  assign status_next[tisl_pkg::BIT_CCA_BUSY] = cca_busy_next;
  assign status_next[tisl_pkg::BIT_CRC_OK]   = crc_ok_next;

  // Status register
  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= tisl_pkg::STATUS_RESET[tisl_pkg::LOW_BITS-1:0];
    end else begin
      status_reg <= status_next;
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************

  // Read returns the value before the clear; other addresses read zero
  // An event in the read cycle shows in the next read instead
  assign rd_data_next = status_read ?
                        {{(tisl_pkg::DATA_W-tisl_pkg::LOW_BITS){1'b0}}, status_reg} :
                        '0;

  // Read data and its valid flag, one cycle after the strobe
  // Every strobe is answered, even one to an unmapped address
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_reg  <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= reg_rd_en;
    end
  end

  // ****************************************************************
  // Interrupt request and doze wake
  // ****************************************************************

  // Request from next state, so the pin releases in step with the clear
  // Bits 1 and 0 are results and are masked out of the request
  assign irq_n_next = ~|(status_next & irq_enable & tisl_pkg::EVENT_MASK);

  // Registered pin drive and doze exit pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_n_reg     <= 1'b1;
      doze_wake_reg <= 1'b0;
    end else begin
      irq_n_reg     <= irq_n_next;
      doze_wake_reg <= doze_event;
    end
  end

  // Outputs straight from flip-flops
  // No logic after the flops keeps the pin and port glitch free
  assign reg_rd_data  = rd_data_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign irq_n        = irq_n_reg;
  assign doze_wake    = doze_wake_reg;

endmodule

// ### verilog/tisl_pkg.sv
// Constants shared by the transceiver interrupt status logic
package tisl_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W        = 6;
  localparam int          DATA_W        = 16;
  localparam logic [5:0]  STATUS_OFFSET = 6'h24;
  localparam logic [15:0] STATUS_RESET  = 16'h0000;

  // ****************************************************************
  // Field positions in the interrupt event status register
  // ****************************************************************
  localparam int BIT_ATTN      = 10;
  localparam int BIT_DOZE      = 9;
  localparam int BIT_CMP_ONE   = 8;
  localparam int BIT_RX_EVENT  = 7;
  localparam int BIT_TX_EVENT  = 6;
  localparam int BIT_CCA_DONE  = 5;
  localparam int BIT_CMP_THREE = 4;
  localparam int BIT_CMP_FOUR  = 3;
  localparam int BIT_CMP_TWO   = 2;
  localparam int BIT_CCA_BUSY  = 1;
  localparam int BIT_CRC_OK    = 0;

  // Number of implemented low bits; bits above read as zero
  localparam int LOW_BITS = 11;

  // Sticky event bits, cleared by a read of the status register
  localparam logic [10:0] EVENT_MASK = 11'h7FC;

  // ****************************************************************
  // Timer and assessment encodings
  // ****************************************************************
  localparam int         TIMER_W        = 24;
  localparam int         STREAM_CMP_W   = 16;
  localparam int         NUM_CMP        = 4;
  localparam logic [1:0] CCA_TYPE_ENERGY = 2'h2;

endpackage
